// file: shared/sdct_map.svh
// Timing counts, mode register fields and reset values for the DRAM link
`ifndef SDCT_MAP_SVH
`define SDCT_MAP_SVH

// System clock and link clock derived from it
`define SDCT_CLK_NS 100
`define SDCT_LINK_DIV 8
`define SDCT_LINK_NS (`SDCT_CLK_NS * `SDCT_LINK_DIV)
`define SDCT_CEIL_CYC(ns) (((ns) + `SDCT_LINK_NS - 1) / `SDCT_LINK_NS)

// Spacings already given in link clocks
`define SDCT_MODE_LOAD_TO_CMD_GAP 2
`define SDCT_COL_CMD_SPACING 1
`define SDCT_LAST_WDATA_TO_COL_CMD 1
`define SDCT_LAST_WDATA_TO_STOP 1
`define SDCT_WDATA_TO_ACTIVATE_AUTOCLOSE 5
`define SDCT_WDATA_TO_PRECHARGE 2
`define SDCT_WRITE_CMD_TO_DATA_DELAY 0
`define SDCT_MASK_WRITE_LATENCY 0
`define SDCT_MASK_READ_FLOAT_LATENCY 2
`define SDCT_CLK_ENABLE_LOW_LATENCY 1
`define SDCT_CLK_ENABLE_HIGH_LATENCY 1
`define SDCT_SELF_EXIT_TOGGLES 2

// Minimum times, the refresh window and the refresh row count, in their own units
`define SDCT_ACTIVATE_TO_COLUMN_DELAY_NS 20
`define SDCT_PRECHARGE_NS 20
`define SDCT_AUTO_REFRESH_NS 66
`define SDCT_SELF_REFRESH_EXIT_GAP_NS 75
`define SDCT_POWERUP_WAIT_US 100
`define SDCT_FULL_REFRESH_WINDOW_MS 64
`define SDCT_REFRESH_ROWS 8192

// Link clock counts derived from the times above
`define SDCT_RCD_CYC `SDCT_CEIL_CYC(`SDCT_ACTIVATE_TO_COLUMN_DELAY_NS)
`define SDCT_RP_CYC `SDCT_CEIL_CYC(`SDCT_PRECHARGE_NS)
`define SDCT_RFC_CYC `SDCT_CEIL_CYC(`SDCT_AUTO_REFRESH_NS)
`define SDCT_XSR_RAW `SDCT_CEIL_CYC(`SDCT_SELF_REFRESH_EXIT_GAP_NS)
`define SDCT_XSR_CYC ((`SDCT_XSR_RAW < `SDCT_SELF_EXIT_TOGGLES) ? \
	`SDCT_SELF_EXIT_TOGGLES : `SDCT_XSR_RAW)
`define SDCT_INIT_CYC `SDCT_CEIL_CYC(`SDCT_POWERUP_WAIT_US * 1000)
`define SDCT_REF_INT_CYC ((`SDCT_FULL_REFRESH_WINDOW_MS * 1000000 / \
	`SDCT_REFRESH_ROWS) / `SDCT_LINK_NS)
`define SDCT_REF_LATE_CYC (2 * `SDCT_REF_INT_CYC)

// Mode register layout and the value the controller loads
`define SDCT_MODE_BL_LSB 0
`define SDCT_MODE_CL_LSB 4
`define SDCT_MODE_CL_DEF 2
`define SDCT_MODE_RST 13'h0020
`define SDCT_AUTO_CLOSE_BIT 10
`define SDCT_MAX_CL 3

`endif

// file: shared/sdct_pkg.sv
// Command codes and controller states shared by both link ends
package sdct_pkg;

	// Select, row strobe, column strobe, write enable, all active low
	typedef enum logic [3:0] {
		CMD_LMR = 4'h0,
		CMD_REF = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WR = 4'h4,
		CMD_RD = 4'h5,
		CMD_STOP = 4'h6,
		CMD_NOP = 4'h7
	} sdct_cmd_t;

	typedef enum logic [5:0] {
		ST_INIT = 6'h01,
		ST_REF = 6'h02,
		ST_LMR = 6'h04,
		ST_IDLE = 6'h08,
		ST_RW = 6'h10,
		ST_SLEEP = 6'h20
	} sdct_state_t;

endpackage : sdct_pkg

// file: shared/sdct_if.sv
// Link pins between the memory controller and the memory device
`timescale 1ns/1ns
`default_nettype none
interface sdct_if;
	logic lclk;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] ba;
	logic [12:0] addr;
	logic dqm;
	logic [15:0] ctl_dq_o;
	logic ctl_dq_oe_n;
	logic [15:0] dev_dq_o;
	logic dev_dq_oe_n;
	logic [15:0] dq;

	// Shared data bus; an undriven bus reads as pulled up
	assign dq = !ctl_dq_oe_n ? ctl_dq_o :
		(!dev_dq_oe_n ? dev_dq_o : 16'hffff);

	modport ctl (output lclk, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
		dqm, ctl_dq_o, ctl_dq_oe_n, input dq);
	modport dev (input lclk, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
		dqm, dq, output dev_dq_o, dev_dq_oe_n);
endinterface : sdct_if
`default_nettype wire

// file: core/sdct_dev.sv
// Memory device end: command decode, small storage, read pipeline
`timescale 1ns/1ns
`default_nettype none
`include "sdct_map.svh"
module sdct_dev (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic ce, // Clock enable, freezes all state
	sdct_if.dev link, // Link pins
	output logic [3:0] bank_open, // Banks with an open row
	output logic in_self_refresh, // Self refresh active
	output logic refresh_pulse // One cycle per auto refresh
);
	import sdct_pkg::*;

	logic [37:0] pin_s1;
	logic [37:0] pin_s2;
	logic lclk_s3;
	logic cke_prev_reg;
	logic self_reg;
	logic [12:0] mode_reg;
	logic [3:0] open_reg;
	logic refresh_reg;
	logic [3:0] burst_left_reg;
	logic [3:0] burst_col_reg;
	logic [1:0] burst_ba_reg;
	logic burst_wr_reg;
	logic burst_auto_reg;
	logic [15:0] pipe_d [`SDCT_MAX_CL];
	logic [2:0] pipe_v;
	logic [1:0] mask_p;
	logic [15:0] dq_o_reg;
	logic dq_oe_n_reg;
	logic [15:0] mem [64];
	logic edge_ok;
	logic act;
	logic [3:0] cmd;
	logic s_cke;
	logic [1:0] s_ba;
	logic [12:0] s_addr;
	logic s_dqm;
	logic [15:0] s_din;
	logic [3:0] bl;
	logic [1:0] cl_idx;
	logic new_v;
	logic [15:0] new_d;
	logic burst_run;

	// Every pin passes two flops; the link clock gets a third for edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= 38'h0;
			pin_s2 <= 38'h0;
			lclk_s3 <= 1'b0;
		end else if (ce) begin
			pin_s1 <= {link.lclk, link.cke, link.cs_n, link.ras_n, link.cas_n,
				link.we_n, link.ba, link.addr, link.dqm, link.dq};
			pin_s2 <= pin_s1;
			lclk_s3 <= pin_s2[37];
		end
	end

	assign s_cke = pin_s2[36];
	assign cmd = pin_s2[35:32];
	assign s_ba = pin_s2[31:30];
	assign s_addr = pin_s2[29:17];
	assign s_dqm = pin_s2[16];
	assign s_din = pin_s2[15:0];
	assign edge_ok = ce && pin_s2[37] && !lclk_s3;
	// Edge counts only if enable was high at the previous edge
	assign act = edge_ok && cke_prev_reg && !self_reg;
	assign bl = 4'h1 << mode_reg[`SDCT_MODE_BL_LSB +: 2];
	assign cl_idx = (mode_reg[`SDCT_MODE_CL_LSB +: 2] == 2'h0) ? 2'h0 :
		mode_reg[`SDCT_MODE_CL_LSB +: 2] - 2'h1;
	// A stop, precharge or new column command cuts the running burst
	assign burst_run = (burst_left_reg != 4'h0) && (cmd != CMD_PRE) &&
		(cmd != CMD_STOP) && (cmd != CMD_RD) && (cmd != CMD_WR);

	// Word entering the read pipeline at this edge
	always_comb begin
		new_v = 1'b0;
		new_d = mem[{burst_ba_reg, burst_col_reg}];
		if (cmd == CMD_RD) begin
			new_v = 1'b1;
			new_d = mem[{s_ba, s_addr[3:0]}];
		end else if (burst_run && !burst_wr_reg) begin
			new_v = 1'b1;
		end
	end

	// Enable history, self refresh and mode register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cke_prev_reg <= 1'b1;
			self_reg <= 1'b0;
			mode_reg <= `SDCT_MODE_RST;
			refresh_reg <= 1'b0;
		end else if (ce) begin
			refresh_reg <= act && cmd == CMD_REF && s_cke;
			if (edge_ok) begin
				cke_prev_reg <= s_cke;
				if (self_reg && s_cke) begin
					self_reg <= 1'b0;
				end else if (act && cmd == CMD_REF && !s_cke) begin
					self_reg <= 1'b1;
				end
			end
			if (act && cmd == CMD_LMR) begin
				mode_reg <= s_addr;
			end
		end
	end

	// Burst tracking and open rows
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			burst_left_reg <= 4'h0;
			burst_col_reg <= 4'h0;
			burst_ba_reg <= 2'h0;
			burst_wr_reg <= 1'b0;
			burst_auto_reg <= 1'b0;
			open_reg <= 4'h0;
		end else if (act) begin
			unique case (cmd)
				CMD_RD, CMD_WR: begin
					burst_left_reg <= bl - 4'h1;
					burst_col_reg <= s_addr[3:0] + 4'h1;
					burst_ba_reg <= s_ba;
					burst_wr_reg <= cmd == CMD_WR;
					burst_auto_reg <= s_addr[`SDCT_AUTO_CLOSE_BIT];
					if (s_addr[`SDCT_AUTO_CLOSE_BIT] && bl == 4'h1) begin
						open_reg[s_ba] <= 1'b0;
					end
				end
				CMD_ACT: open_reg[s_ba] <= 1'b1;
				CMD_PRE: begin
					burst_left_reg <= 4'h0;
					if (s_addr[`SDCT_AUTO_CLOSE_BIT]) begin
						open_reg <= 4'h0;
					end else begin
						open_reg[s_ba] <= 1'b0;
					end
				end
				CMD_STOP: burst_left_reg <= 4'h0;
				default: begin
					if (burst_left_reg != 4'h0) begin
						burst_left_reg <= burst_left_reg - 4'h1;
						burst_col_reg <= burst_col_reg + 4'h1;
						if (burst_left_reg == 4'h1 && burst_auto_reg) begin
							open_reg[burst_ba_reg] <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// Storage: data taken with the command, mask acts at once
	always_ff @(posedge clk) begin
		if (act && cmd == CMD_WR && !s_dqm) begin
			mem[{s_ba, s_addr[3:0]}] <= s_din;
		end else if (act && burst_run && burst_wr_reg && !s_dqm) begin
			mem[{burst_ba_reg, burst_col_reg}] <= s_din;
		end
	end

	// Read pipeline, one stage per latency clock
	genvar i;
	generate
		for (i = 0; i < `SDCT_MAX_CL; i++) begin : g_pipe
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					pipe_d[i] <= 16'h0;
					pipe_v[i] <= 1'b0;
				end else if (act) begin
					pipe_d[i] <= (i == 0) ? new_d : pipe_d[(i == 0) ? 0 : i - 1];
					pipe_v[i] <= (i == 0) ? new_v : pipe_v[(i == 0) ? 0 : i - 1];
				end
			end
		end
	endgenerate

	// Mask history: a mask seen two edges back floats the bus
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask_p <= 2'h0;
			dq_o_reg <= 16'h0;
			dq_oe_n_reg <= 1'b1;
		end else if (ce) begin
			if (act) begin
				mask_p <= {mask_p[0], s_dqm};
			end
			dq_o_reg <= pipe_d[cl_idx];
			dq_oe_n_reg <= !(pipe_v[cl_idx] && !mask_p[1]);
		end
	end

	assign link.dev_dq_o = dq_o_reg;
	assign link.dev_dq_oe_n = dq_oe_n_reg;
	assign bank_open = open_reg;
	assign in_self_refresh = self_reg;
	assign refresh_pulse = refresh_reg;
endmodule : sdct_dev
`default_nettype wire

// file: core/sdct_ctl.sv
// Memory controller end: init, refresh, single-word accesses, sleep
`timescale 1ns/1ns
`default_nettype none
`include "sdct_map.svh"
module sdct_ctl (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic ce, // Clock enable, freezes all state
	sdct_if.ctl link, // Link pins
	input wire logic req_valid, // Access request
	input wire logic req_write, // 1 write, 0 read
	input wire logic [1:0] req_bank, // Bank
	input wire logic [12:0] req_row, // Row
	input wire logic [8:0] req_col, // Column
	input wire logic [15:0] req_wdata, // Write data
	input wire logic req_wmask, // Suppress the write data
	input wire logic sleep_req, // Hold device in self refresh
	output logic req_ready, // Request taken, one cycle
	output logic rd_valid, // Read data valid, one cycle
	output logic [15:0] rd_data, // Read data
	output logic init_done, // Start-up sequence complete
	output logic asleep // Device in self refresh
);
	import sdct_pkg::*;

	logic [1:0] div_reg;
	logic lclk_reg;
	logic step;
	logic cap;
	logic [15:0] dq_s1;
	logic [15:0] dq_s2;
	sdct_state_t state_reg;
	logic [7:0] wait_reg;
	logic [1:0] ref_left_reg;
	logic mode_done_reg;
	sdct_cmd_t cmd_reg;
	logic cke_reg;
	logic [1:0] ba_reg;
	logic [12:0] addr_reg;
	logic dqm_reg;
	logic [15:0] dq_o_reg;
	logic dq_oe_n_reg;
	logic req_ready_reg;
	logic asleep_reg;
	logic lat_write;
	logic [8:0] lat_col;
	logic [15:0] lat_wdata;
	logic lat_wmask;
	logic [7:0] ref_cnt_reg;
	logic [2:0] rd_cnt_reg;
	logic rd_valid_reg;
	logic [15:0] rd_data_reg;
	logic cmd_slot;
	logic ref_fire;
	logic rd_fire;

	// Link clock by division; half period of four system clocks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= 2'h0;
			lclk_reg <= 1'b0;
		end else if (ce) begin
			div_reg <= div_reg + 2'h1;
			if (div_reg == 2'h3) begin
				lclk_reg <= !lclk_reg;
			end
		end
	end

	// Pins change on the falling link edge, data is taken on the rising
	assign step = ce && div_reg == 2'h3 && lclk_reg;
	assign cap = ce && div_reg == 2'h3 && !lclk_reg;
	assign cmd_slot = step && wait_reg == 8'h00;
	assign ref_fire = cmd_slot && state_reg == ST_REF;
	assign rd_fire = cmd_slot && state_reg == ST_RW && !lat_write;

	// Data bus comes back from another device, so two flops first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dq_s1 <= 16'h0;
			dq_s2 <= 16'h0;
		end else if (ce) begin
			dq_s1 <= link.dq;
			dq_s2 <= dq_s1;
		end
	end

	// Command sequencer; every wait is a count of NOP link clocks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_INIT;
			wait_reg <= 8'(`SDCT_INIT_CYC);
			ref_left_reg <= 2'h0;
			mode_done_reg <= 1'b0;
			cmd_reg <= CMD_NOP;
			cke_reg <= 1'b1;
			ba_reg <= 2'h0;
			addr_reg <= 13'h0;
			dqm_reg <= 1'b0;
			dq_o_reg <= 16'h0;
			dq_oe_n_reg <= 1'b1;
			req_ready_reg <= 1'b0;
			asleep_reg <= 1'b0;
			lat_write <= 1'b0;
			lat_col <= 9'h0;
			lat_wdata <= 16'h0;
			lat_wmask <= 1'b0;
		end else if (ce) begin
			req_ready_reg <= 1'b0;
			if (step) begin
				cmd_reg <= CMD_NOP;
				dq_oe_n_reg <= 1'b1;
				dqm_reg <= 1'b0;
				if (wait_reg != 8'h00) begin
					wait_reg <= wait_reg - 8'h01;
				end else begin
					unique case (state_reg)
						ST_INIT: begin
							// Close every bank before the wake-up refreshes
							cmd_reg <= CMD_PRE;
							addr_reg <= 13'h0400;
							wait_reg <= 8'(`SDCT_RP_CYC - 1);
							ref_left_reg <= 2'h2;
							state_reg <= ST_REF;
						end
						ST_REF: begin
							cmd_reg <= CMD_REF;
							wait_reg <= 8'(`SDCT_RFC_CYC - 1);
							ref_left_reg <= ref_left_reg - 2'h1;
							if (ref_left_reg == 2'h1) begin
								state_reg <= mode_done_reg ? ST_IDLE : ST_LMR;
							end
						end
						ST_LMR: begin
							cmd_reg <= CMD_LMR;
							ba_reg <= 2'h0;
							addr_reg <= `SDCT_MODE_RST;
							wait_reg <= 8'(`SDCT_MODE_LOAD_TO_CMD_GAP - 1);
							mode_done_reg <= 1'b1;
							state_reg <= ST_IDLE;
						end
						ST_IDLE: begin
							if (ref_cnt_reg >= 8'(`SDCT_REF_INT_CYC - 2)) begin
								// Late refresh redoes the two-refresh wake-up
								ref_left_reg <= (ref_cnt_reg >=
									8'(`SDCT_REF_LATE_CYC)) ? 2'h2 : 2'h1;
								state_reg <= ST_REF;
							end else if (sleep_req) begin
								// Refresh with enable low enters self refresh
								cke_reg <= 1'b0;
								cmd_reg <= CMD_REF;
								asleep_reg <= 1'b1;
								state_reg <= ST_SLEEP;
							end else if (req_valid) begin
								cmd_reg <= CMD_ACT;
								ba_reg <= req_bank;
								addr_reg <= req_row;
								lat_write <= req_write;
								lat_col <= req_col;
								lat_wdata <= req_wdata;
								lat_wmask <= req_wmask;
								req_ready_reg <= 1'b1;
								wait_reg <= 8'(`SDCT_RCD_CYC - 1);
								state_reg <= ST_RW;
							end
						end
						ST_RW: begin
							// Single word with automatic row close
							addr_reg <= {3'h1, 1'b0, lat_col};
							if (lat_write) begin
								cmd_reg <= CMD_WR;
								dq_o_reg <= lat_wdata;
								dq_oe_n_reg <= 1'b0;
								dqm_reg <= lat_wmask;
								// Covers recovery, next column and stop spacing
								wait_reg <= 8'(`SDCT_WDATA_TO_ACTIVATE_AUTOCLOSE
									- 1);
							end else begin
								cmd_reg <= CMD_RD;
								wait_reg <= 8'(`SDCT_MODE_CL_DEF + `SDCT_RP_CYC - 1);
							end
							state_reg <= ST_IDLE;
						end
						ST_SLEEP: begin
							if (!sleep_req) begin
								cke_reg <= 1'b1;
								asleep_reg <= 1'b0;
								// Link clock keeps running through the exit wait
								wait_reg <= 8'(`SDCT_CLK_ENABLE_HIGH_LATENCY +
									`SDCT_XSR_CYC - 1);
								state_reg <= ST_IDLE;
							end
						end
						default: state_reg <= ST_INIT;
					endcase
				end
			end
		end
	end

	// Link clocks since the last refresh; self refresh keeps rows alive
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_cnt_reg <= 8'h0;
		end else if (step) begin
			if (ref_fire || state_reg == ST_SLEEP) begin
				ref_cnt_reg <= 8'h0;
			end else if (ref_cnt_reg != 8'hff) begin
				ref_cnt_reg <= ref_cnt_reg + 8'h01;
			end
		end
	end

	// Read data taken at the rising edge CAS latency after the command
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_cnt_reg <= 3'h0;
			rd_valid_reg <= 1'b0;
			rd_data_reg <= 16'h0;
		end else if (ce) begin
			rd_valid_reg <= 1'b0;
			if (rd_fire) begin
				rd_cnt_reg <= 3'(`SDCT_MODE_CL_DEF + 1);
			end else if (cap && rd_cnt_reg != 3'h0) begin
				rd_cnt_reg <= rd_cnt_reg - 3'h1;
				if (rd_cnt_reg == 3'h1) begin
					rd_valid_reg <= 1'b1;
					rd_data_reg <= dq_s2;
				end
			end
		end
	end

	assign link.lclk = lclk_reg;
	assign link.cke = cke_reg;
	assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_reg;
	assign link.ba = ba_reg;
	assign link.addr = addr_reg;
	assign link.dqm = dqm_reg;
	assign link.ctl_dq_o = dq_o_reg;
	assign link.ctl_dq_oe_n = dq_oe_n_reg;
	assign req_ready = req_ready_reg;
	assign rd_valid = rd_valid_reg;
	assign rd_data = rd_data_reg;
	assign init_done = mode_done_reg;
	assign asleep = asleep_reg;
endmodule : sdct_ctl
`default_nettype wire

// file: verif/sdct_asserts.sv
// Link timing checker for the DRAM command link
`timescale 1ns/1ns
`default_nettype none
`include "sdct_map.svh"
module sdct_asserts (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset
	input wire logic lclk, // Link clock
	input wire logic cke, // Clock enable
	input wire logic cs_n, // Select
	input wire logic ras_n, // Row strobe
	input wire logic cas_n, // Column strobe
	input wire logic we_n, // Write enable
	input wire logic [12:0] addr, // Address
	input wire logic ctl_dq_oe_n, // Controller drives, low
	input wire logic dev_dq_oe_n // Device drives, low
);
	import sdct_pkg::*;
	logic lclk_reg;
	logic cke_reg;
	logic [7:0] lmr_reg, wr_reg, act_reg, ckr_reg, ref_reg, rst_reg;
	logic [1:0] nref_reg;
	logic e;
	sdct_cmd_t cmd;

	// Device samples pins on the link's rising edge
	assign e = lclk & ~lclk_reg;
	assign cmd = sdct_cmd_t'({cs_n, ras_n, cas_n, we_n});

	// Saturating gap count, so long idle spans cannot wrap
	function automatic logic [7:0] bump(input logic [7:0] v,
		input logic hit);
		return hit ? 8'h01 : ((v == 8'hff) ? v : v + 8'h01);
	endfunction : bump

	// Link edges since reset, since enable rise and since each command of interest
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lclk_reg <= 1'b0;
			cke_reg <= 1'b1;
			lmr_reg <= 8'hff;
			wr_reg <= 8'hff;
			act_reg <= 8'hff;
			ckr_reg <= 8'hff;
			ref_reg <= 8'hff;
			rst_reg <= 8'h00;
			nref_reg <= 2'h0;
		end else begin
			lclk_reg <= lclk;
			if (e) begin
				cke_reg <= cke;
				lmr_reg <= bump(lmr_reg, cmd == CMD_LMR);
				wr_reg <= bump(wr_reg, cmd == CMD_WR);
				act_reg <= bump(act_reg, cmd == CMD_ACT);
				ckr_reg <= bump(ckr_reg, cke && !cke_reg);
				ref_reg <= bump(ref_reg, cmd == CMD_REF || !cke);
				rst_reg <= bump(rst_reg, 1'b0);
				if (cmd == CMD_REF && cke && nref_reg != 2'h2) begin
					nref_reg <= nref_reg + 2'h1;
				end
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_mode_gap;
		e && (cmd == CMD_ACT || cmd == CMD_REF) |->
			lmr_reg >= `SDCT_MODE_LOAD_TO_CMD_GAP;
	endproperty
	a_mode_gap: assert property (p_mode_gap)
		else $error("mode load gap too short");
	property p_wdata_with_cmd;
		e && cmd == CMD_WR |-> !ctl_dq_oe_n;
	endproperty
	a_wdata_with_cmd: assert property (p_wdata_with_cmd)
		else $error("write data not driven with command");
	property p_autoclose;
		e && (cmd == CMD_WR || cmd == CMD_RD) |-> addr[10];
	endproperty
	a_autoclose: assert property (p_autoclose)
		else $error("column command without auto close");
	property p_act_col;
		e && (cmd == CMD_WR || cmd == CMD_RD) |-> act_reg >= `SDCT_RCD_CYC;
	endproperty
	a_act_col: assert property (p_act_col)
		else $error("column command too soon after activate");
	property p_wdata_act;
		e && cmd == CMD_ACT |-> wr_reg >= `SDCT_WDATA_TO_ACTIVATE_AUTOCLOSE;
	endproperty
	a_wdata_act: assert property (p_wdata_act)
		else $error("activate too soon after write");
	property p_wdata_pre;
		e && cmd == CMD_PRE |-> wr_reg >= `SDCT_WDATA_TO_PRECHARGE;
	endproperty
	a_wdata_pre: assert property (p_wdata_pre)
		else $error("precharge too soon after write");
	property p_self_exit;
		e && cmd == CMD_ACT |-> ckr_reg >= `SDCT_XSR_CYC;
	endproperty
	a_self_exit: assert property (p_self_exit)
		else $error("activate too soon after self refresh");
	property p_init_wait;
		e && cmd != CMD_NOP |-> rst_reg >= `SDCT_INIT_CYC;
	endproperty
	a_init_wait: assert property (p_init_wait)
		else $error("command before power-up pause");
	property p_two_refs;
		e && cmd == CMD_ACT |-> nref_reg == 2'h2;
	endproperty
	a_two_refs: assert property (p_two_refs)
		else $error("activate before two refreshes");
	property p_ref_interval;
		e && cke && ref_reg != 8'hff |-> ref_reg <= `SDCT_REF_LATE_CYC + 8;
	endproperty
	a_ref_interval: assert property (p_ref_interval)
		else $error("refresh overdue");
	property p_read_float;
		e && cmd == CMD_RD |-> ##[1:40] !dev_dq_oe_n ##[1:40] dev_dq_oe_n;
	endproperty
	a_read_float: assert property (p_read_float)
		else $error("read data not driven then floated");

	// Main traffic seen at least once
	c_write: cover property (e && cmd == CMD_WR);
	c_read: cover property (e && cmd == CMD_RD);
	c_sleep: cover property (e && cmd == CMD_REF && !cke);
	c_wake: cover property (e && ckr_reg == 8'h01);
endmodule : sdct_asserts
`default_nettype wire

// file: verif/sdram_command_timing_rules_tb_top.sv
// Self-checking bench: controller and device joined over the link
`timescale 1ns/1ns
`default_nettype none
`include "sdct_map.svh"
`define CHK(got, exp, msg) begin \
	n_compared++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("MISMATCH t=%0t %s", $time, msg); \
	end \
end
module sdram_command_timing_rules_tb_top;
	logic clk, rst, ce, req_valid, req_write, req_wmask, sleep_req;
	logic [1:0] req_bank;
	logic [12:0] req_row;
	logic [8:0] req_col;
	logic [15:0] req_wdata, rd_data;
	logic req_ready, rd_valid, init_done, asleep;
	logic [3:0] bank_open;
	logic in_self_refresh, refresh_pulse;
	logic [15:0] mem [64];
	bit wr_ok [64];
	int failures, n_compared, seed, n, i;
	logic [31:0] r, wdat;

	sdct_if i_sdct_if();
	sdct_ctl i_sdct_ctl(.clk(clk), .rst(rst), .ce(ce),
		.link(i_sdct_if.ctl), .req_valid(req_valid), .req_write(req_write),
		.req_bank(req_bank), .req_row(req_row), .req_col(req_col),
		.req_wdata(req_wdata), .req_wmask(req_wmask), .sleep_req(sleep_req),
		.req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.init_done(init_done), .asleep(asleep));
	sdct_dev i_sdct_dev(.clk(clk), .rst(rst), .ce(ce),
		.link(i_sdct_if.dev), .bank_open(bank_open),
		.in_self_refresh(in_self_refresh), .refresh_pulse(refresh_pulse));
	sdct_asserts i_sdct_asserts(.clk(clk), .rst(rst),
		.lclk(i_sdct_if.lclk), .cke(i_sdct_if.cke), .cs_n(i_sdct_if.cs_n),
		.ras_n(i_sdct_if.ras_n), .cas_n(i_sdct_if.cas_n),
		.we_n(i_sdct_if.we_n), .addr(i_sdct_if.addr),
		.ctl_dq_oe_n(i_sdct_if.ctl_dq_oe_n),
		.dev_dq_oe_n(i_sdct_if.dev_dq_oe_n));

	// Free-running system clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic test_done;
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	// Refreshes expected in an idle span of system clocks
	function automatic int exp_refs(input int span);
		return span / (`SDCT_REF_INT_CYC * `SDCT_LINK_DIV);
	endfunction : exp_refs

	// One access; model tracks only words actually stored
	task automatic access(input logic w, input logic [1:0] b,
		input logic [12:0] rw, input logic [8:0] c, input logic [15:0] d,
		input logic m);
		int k;
		logic [5:0] idx;
		idx = {b, c[3:0]};
		@(negedge clk);
		req_valid = 1'b1;
		req_write = w;
		req_bank = b;
		req_row = rw;
		req_col = c;
		req_wdata = d;
		req_wmask = m;
		k = 0;
		do begin
			@(posedge clk);
			#1 k++;
		end while (req_ready !== 1'b1 && k < 3000);
		`CHK(req_ready, 1'b1, "request not taken")
		`CHK(init_done, 1'b1, "taken before start-up")
		@(negedge clk);
		req_valid = 1'b0;
		if (w) begin
			if (!m) begin
				mem[idx] = d;
				wr_ok[idx] = 1'b1;
			end
		end else begin
			k = 0;
			do begin
				@(posedge clk);
				#1 k++;
			end while (rd_valid !== 1'b1 && k < 200);
			`CHK(rd_valid, 1'b1, "no read data")
			if (wr_ok[idx]) `CHK(rd_data, mem[idx], "read data")
		end
	endtask : access

	// Cut a hang short
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		test_done();
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_bank = 2'h0;
		req_row = 13'h0000;
		req_col = 9'h000;
		req_wdata = 16'h0000;
		req_wmask = 1'b0;
		sleep_req = 1'b0;
		failures = 0;
		n_compared = 0;
		seed = 59091;
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		`CHK(i_sdct_if.cke, 1'b1, "cke after reset")
		`CHK(init_done, 1'b0, "ready too early")
		n = 0;
		while (init_done !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(n >= `SDCT_INIT_CYC * `SDCT_LINK_DIV, 1'b1, "pause short")
		// Corner rows, columns and data in every bank
		for (i = 0; i < 4; i++) begin
			access(1'b1, i[1:0], 13'h1fff, 9'h000, 16'h0000, 1'b0);
			access(1'b1, i[1:0], 13'h0000, 9'h00f, 16'hffff, 1'b0);
			access(1'b0, i[1:0], 13'h0000, 9'h000, 16'h0000, 1'b0);
			access(1'b0, i[1:0], 13'h1fff, 9'h00f, 16'h0000, 1'b0);
		end
		// Masked write must leave the old word
		access(1'b1, 2'h2, 13'h0005, 9'h003, 16'ha5a5, 1'b0);
		access(1'b1, 2'h2, 13'h0005, 9'h003, 16'h5a5a, 1'b1);
		access(1'b0, 2'h2, 13'h0005, 9'h003, 16'h0000, 1'b0);
		repeat (80) @(posedge clk);
		#1 `CHK(bank_open, 4'h0, "row left open")
		for (i = 0; i < 40; i++) begin
			r = $random(seed);
			wdat = $random(seed);
			access(r[0], r[2:1], r[15:3], r[24:16], wdat[15:0], r[25]);
		end
		// Idle: refresh keeps its pace
		n = 0;
		repeat (1600) begin
			@(posedge clk);
			#1 if (refresh_pulse === 1'b1) n++;
		end
		`CHK(n >= exp_refs(1600) - 1, 1'b1, "few refs")
		`CHK(n <= exp_refs(1600) + 1, 1'b1, "many refs")
		// Self refresh entry and exit
		@(negedge clk);
		sleep_req = 1'b1;
		n = 0;
		while (asleep !== 1'b1 && n < 800) begin
			@(posedge clk);
			#1 n++;
		end
		repeat (40) @(posedge clk);
		#1 `CHK(in_self_refresh, 1'b1, "device not asleep")
		`CHK(i_sdct_if.cke, 1'b0, "cke stays high")
		`CHK(asleep, 1'b1, "controller not asleep")
		@(negedge clk);
		sleep_req = 1'b0;
		n = 0;
		while (asleep !== 1'b0 && n < 800) begin
			@(posedge clk);
			#1 n++;
		end
		repeat (40) @(posedge clk);
		#1 `CHK(in_self_refresh, 1'b0, "device still asleep")
		`CHK(asleep, 1'b0, "controller still asleep")
		access(1'b0, 2'h2, 13'h0005, 9'h003, 16'h0000, 1'b0);
		test_done();
	end
endmodule : sdram_command_timing_rules_tb_top
`default_nettype wire
